// *** hpt_consts.svh ***
// constants for the high-side switch pwm and timer register block
`ifndef HPT_CONSTS_SVH
`define HPT_CONSTS_SVH
// ****************************************************************
// clock and timing
// ****************************************************************
`define HPT_CLK_HZ          50000000
`define HPT_CLK_PERIOD_NS   20
`define HPT_PWM_SLOW_HZ     200
`define HPT_PWM_FAST_HZ     400
`define HPT_PWM_FULL_SCALE  10'h3FF
`define HPT_PWM_SLOW_CYC    (`HPT_CLK_HZ / (`HPT_PWM_SLOW_HZ * 1023))
`define HPT_PWM_FAST_CYC    (`HPT_CLK_HZ / (`HPT_PWM_FAST_HZ * 1023))
`define HPT_TICK_NS         100000
`define HPT_TICK_CYC        (`HPT_TICK_NS / `HPT_CLK_PERIOD_NS)
// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define HPT_IDX_RATE        8'h22
`define HPT_IDX_DUTY_HI     8'h23
`define HPT_IDX_DUTY_LO     8'h24
`define HPT_IDX_TIMER       8'h25
`define HPT_IDX_STATUS      8'h26
// ****************************************************************
// field positions and codes
// ****************************************************************
`define HPT_RATE_BIT        7
`define HPT_TW_HI           7
`define HPT_TW_LO           4
`define HPT_TP_HI           2
`define HPT_TP_LO           0
`define HPT_TW_OFF          4'h0
`define HPT_TW_ON           4'hF
`define HPT_RESP_OKAY       2'h0
`define HPT_RESP_SLVERR     2'h2
`endif

// *** hpt_pkg.sv ***
// types shared by the high-side switch pwm and timer block
`default_nettype none
package hpt_pkg;
   // pwm channel configuration
   typedef struct packed {
      logic       rate;
      logic [9:0] duty;
   } hpt_pwm_cfg_t;
   // pwm core state
   typedef struct packed {
      logic [7:0] pre;
      logic [9:0] cnt;
      logic       out;
   } hpt_pwm_st_t;
   // register block state
   typedef struct packed {
      logic        aw_full;
      logic [11:0] awaddr;
      logic        w_full;
      logic [7:0]  wdata;
      logic        wstrb0;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic        rate;
      logic [1:0]  duty_hi;
      logic [7:0]  duty_lo;
      logic [3:0]  tmr_width;
      logic [2:0]  tmr_period;
      logic [12:0] tick_pre;
      logic [14:0] tmr_cnt;
      logic        tmr_out;
   } hpt_top_st_t;
endpackage
`default_nettype wire

// *** hpt_pwm_core.sv ***
// ten-bit pwm generator for the high-side switch
`timescale 1ns/1ps
`default_nettype none
`include "hpt_consts.svh"
module hpt_pwm_core (
   input  wire logic                  clk_in,   // 50 mhz clock
   input  wire logic                  rst_in,   // async reset, high
   input  wire logic                  ce_in,    // clock enable
   input  wire hpt_pkg::hpt_pwm_cfg_t cfg_in,   // rate and duty
   output logic                       pwm_out   // switch drive
);
   hpt_pkg::hpt_pwm_st_t st_r;
   hpt_pkg::hpt_pwm_st_t st_nxt;
   logic [7:0]           step_lim;

   // step length: period split into 1023 slots, rounded down
   always_comb begin
      step_lim = cfg_in.rate ? 8'(`HPT_PWM_FAST_CYC - 1)
                             : 8'(`HPT_PWM_SLOW_CYC - 1);
      st_nxt   = st_r;
      if (st_r.pre >= step_lim) begin
         st_nxt.pre = 8'h00;
         // 1023 slots per period so full scale stays on throughout
         st_nxt.cnt = (st_r.cnt >= `HPT_PWM_FULL_SCALE - 10'h001) ? 10'h000
                                                                : st_r.cnt + 10'h001;
      end else begin
         st_nxt.pre = st_r.pre + 8'h01;
      end
      // on while slot index is below duty: 0 never on, 1023 always on
      st_nxt.out = (st_r.cnt < cfg_in.duty);
   end

   // single state register, frozen while ce is low
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= '0;
      end else if (ce_in) begin
         st_r <= st_nxt;
      end
   end

   assign pwm_out = st_r.out;

   // ****************************************************************
   // checks
   // ****************************************************************
   duty_off_a : assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && cfg_in.duty == 10'h000) |=> !pwm_out)
      else $error("switch on with zero duty");
   duty_full_a : assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && cfg_in.duty == 10'h3FF) |=> pwm_out)
      else $error("switch off with full duty");
   slot_duty_a : assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && st_r.cnt < cfg_in.duty) |=> pwm_out)
      else $error("switch off inside on slots");
   slot_range_a : assert property (@(posedge clk_in) disable iff (rst_in)
      st_r.cnt <= 10'h3FE)
      else $error("slot index beyond 1022");
   step_rate_a : assert property (@(posedge clk_in) disable iff (rst_in)
      (ce_in && st_r.pre == step_lim) |=> st_r.pre == 8'h00)
      else $error("step length wrong for rate");
endmodule
`default_nettype wire

// *** hpt_regs.sv ***
// axi4-lite register block for second pwm channel and first timer
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "hpt_consts.svh"
// Summary of operation
// - duty is high field bits 9:8 joined with low byte bits 7:0
// - duty zero keeps the switch off the whole period
// - duty all ones keeps the switch on the whole period
// - each duty step adds about 0.1 percent on time
// - timer register: width 7:4, reserved bit 3 reads zero, period 2:0
// - rate bit zero gives 200 hz, one gives 400 hz
// - high duty bits sit in 1:0, bits 7:2 read zero
// - timer width zero keeps off, all ones keeps on
module hpt_regs #(
   parameter int TICK_CYC = `HPT_TICK_CYC         // timer tick length in clocks
) (
   input  wire logic        CLK_IN,               // 50 mhz clock
   input  wire logic        SYS_RST_IN,           // async reset, high
   input  wire logic        CE_IN,                // clock enable
   input  wire logic [11:0] S_AXI_AWADDR_IN,      // write address
   input  wire logic        S_AXI_AWVALID_IN,     // write address valid
   output logic             S_AXI_AWREADY_OUT,    // write address ready
   input  wire logic [31:0] S_AXI_WDATA_IN,       // write data
   input  wire logic [3:0]  S_AXI_WSTRB_IN,       // write strobes
   input  wire logic        S_AXI_WVALID_IN,      // write data valid
   output logic             S_AXI_WREADY_OUT,     // write data ready
   output logic [1:0]       S_AXI_BRESP_OUT,      // write response
   output logic             S_AXI_BVALID_OUT,     // write response valid
   input  wire logic        S_AXI_BREADY_IN,      // write response ready
   input  wire logic [11:0] S_AXI_ARADDR_IN,      // read address
   input  wire logic        S_AXI_ARVALID_IN,     // read address valid
   output logic             S_AXI_ARREADY_OUT,    // read address ready
   output logic [31:0]      S_AXI_RDATA_OUT,      // read data
   output logic [1:0]       S_AXI_RRESP_OUT,      // read response
   output logic             S_AXI_RVALID_OUT,     // read data valid
   input  wire logic        S_AXI_RREADY_IN,      // read data ready
   output logic             HSS_PWM_OUT,          // switch drive from pwm
   output logic             HSS_TIMER_OUT         // switch drive from timer
);
   hpt_pkg::hpt_top_st_t st_r;
   hpt_pkg::hpt_top_st_t st_nxt;
   hpt_pkg::hpt_pwm_cfg_t pwm_cfg;
   logic [7:0]            w_idx;
   logic [7:0]            r_idx;
   logic                  w_ok;
   logic                  r_ok;
   logic [14:0]           width_ticks;
   logic [14:0]           period_ticks;

   // ****************************************************************
   // duty assembly and pwm core
   // ****************************************************************
   always_comb begin
      pwm_cfg.rate = st_r.rate;
      pwm_cfg.duty = {st_r.duty_hi, st_r.duty_lo};
   end

   hpt_pwm_core u_pwm (
      .clk_in  (CLK_IN),
      .rst_in  (SYS_RST_IN),
      .ce_in   (CE_IN),
      .cfg_in  (pwm_cfg),
      .pwm_out (HSS_PWM_OUT)
   );

   // timer width and period codes in 0.1 ms ticks
   always_comb begin
      unique case (st_r.tmr_width)
         4'h1:    width_ticks = 15'h0001;
         4'h2:    width_ticks = 15'h0003;
         4'h3:    width_ticks = 15'h0005;
         4'h4:    width_ticks = 15'h000A;
         4'h5:    width_ticks = 15'h0064;
         4'h6:    width_ticks = 15'h00C8;
         4'h7:    width_ticks = 15'h012C;
         4'h8:    width_ticks = 15'h0190;
         4'h9:    width_ticks = 15'h01F4;
         4'hA:    width_ticks = 15'h0258;
         4'hB:    width_ticks = 15'h0320;
         4'hC:    width_ticks = 15'h03E8;
         4'hD:    width_ticks = 15'h05DC;
         4'hE:    width_ticks = 15'h07D0;
         default: width_ticks = 15'h0000;
      endcase
      unique case (st_r.tmr_period)
         3'h0:    period_ticks = 15'h0064;
         3'h1:    period_ticks = 15'h00C8;
         3'h2:    period_ticks = 15'h01F4;
         3'h3:    period_ticks = 15'h03E8;
         3'h4:    period_ticks = 15'h07D0;
         3'h5:    period_ticks = 15'h1388;
         3'h6:    period_ticks = 15'h2710;
         default: period_ticks = 15'h4E20;
      endcase
   end

   // ****************************************************************
   // bus handshake, register writes, timer
   // ****************************************************************
   always_comb begin
      st_nxt = st_r;
      w_idx  = st_r.awaddr[9:2];
      w_ok   = (st_r.awaddr[11:10] == 2'h0) &&
               (w_idx >= `HPT_IDX_RATE) && (w_idx <= `HPT_IDX_TIMER);
      r_idx  = S_AXI_ARADDR_IN[9:2];
      r_ok   = (S_AXI_ARADDR_IN[11:10] == 2'h0) &&
               (r_idx >= `HPT_IDX_RATE) && (r_idx <= `HPT_IDX_STATUS);
      // address and data are caught independently, in either order
      if (S_AXI_AWVALID_IN && st_r.awready) begin
         st_nxt.aw_full = 1'b1;
         st_nxt.awaddr  = S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN && st_r.wready) begin
         st_nxt.w_full = 1'b1;
         st_nxt.wdata  = S_AXI_WDATA_IN[7:0];
         st_nxt.wstrb0 = S_AXI_WSTRB_IN[0];
      end
      if (st_r.bvalid && S_AXI_BREADY_IN) begin
         st_nxt.bvalid = 1'b0;
      end
      // commit once both halves are held; lane 0 strobe gates the store
      if (st_r.aw_full && st_r.w_full && !st_r.bvalid) begin
         st_nxt.aw_full = 1'b0;
         st_nxt.w_full  = 1'b0;
         st_nxt.bvalid  = 1'b1;
         st_nxt.bresp   = w_ok ? `HPT_RESP_OKAY : `HPT_RESP_SLVERR;
         if (w_ok && st_r.wstrb0) begin
            unique case (w_idx)
               `HPT_IDX_RATE:    st_nxt.rate = st_r.wdata[`HPT_RATE_BIT];
               `HPT_IDX_DUTY_HI: st_nxt.duty_hi = st_r.wdata[1:0];
               `HPT_IDX_DUTY_LO: st_nxt.duty_lo = st_r.wdata;
               default: begin
                  st_nxt.tmr_width  = st_r.wdata[`HPT_TW_HI:`HPT_TW_LO];
                  st_nxt.tmr_period = st_r.wdata[`HPT_TP_HI:`HPT_TP_LO];
               end
            endcase
         end
      end
      // reads answer one cycle after the address is taken
      if (st_r.rvalid && S_AXI_RREADY_IN) begin
         st_nxt.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID_IN && st_r.arready) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp  = r_ok ? `HPT_RESP_OKAY : `HPT_RESP_SLVERR;
         st_nxt.rdata  = 8'h00;
         if (r_ok) begin
            unique case (r_idx)
               `HPT_IDX_RATE:    st_nxt.rdata = {st_r.rate, 7'h00};
               `HPT_IDX_DUTY_HI: st_nxt.rdata = {6'h00, st_r.duty_hi};
               `HPT_IDX_DUTY_LO: st_nxt.rdata = st_r.duty_lo;
               `HPT_IDX_TIMER:   st_nxt.rdata = {st_r.tmr_width, 1'b0,
                                                 st_r.tmr_period};
               default:          st_nxt.rdata = {6'h00, st_r.tmr_out, HSS_PWM_OUT};
            endcase
         end
      end
      st_nxt.awready = !st_nxt.aw_full;
      st_nxt.wready  = !st_nxt.w_full;
      st_nxt.arready = !st_nxt.rvalid;
      // timer: tick counter then on-width compare inside the period
      if (st_r.tick_pre >= 13'(TICK_CYC - 1)) begin
         st_nxt.tick_pre = 13'h0000;
         st_nxt.tmr_cnt  = (st_r.tmr_cnt >= period_ticks - 15'h0001) ? 15'h0000
                                                                   : st_r.tmr_cnt + 15'h0001;
      end else begin
         st_nxt.tick_pre = st_r.tick_pre + 13'h0001;
      end
      // width longer than the period simply saturates on
      st_nxt.tmr_out = (st_r.tmr_width == `HPT_TW_ON) ||
                       ((st_r.tmr_width != `HPT_TW_OFF) && (st_r.tmr_cnt < width_ticks));
   end

   // single state register, frozen while ce is low
   always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         st_r         <= '0;
         st_r.awready <= 1'b1;
         st_r.wready  <= 1'b1;
         st_r.arready <= 1'b1;
      end else if (CE_IN) begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state flops
   assign S_AXI_AWREADY_OUT = st_r.awready;
   assign S_AXI_WREADY_OUT  = st_r.wready;
   assign S_AXI_BVALID_OUT  = st_r.bvalid;
   assign S_AXI_BRESP_OUT   = st_r.bresp;
   assign S_AXI_ARREADY_OUT = st_r.arready;
   assign S_AXI_RVALID_OUT  = st_r.rvalid;
   assign S_AXI_RDATA_OUT   = {24'h000000, st_r.rdata};
   assign S_AXI_RRESP_OUT   = st_r.rresp;
   assign HSS_TIMER_OUT     = st_r.tmr_out;

   // ****************************************************************
   // checks
   // ****************************************************************
   duty_join_a : assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && st_r.aw_full && st_r.w_full && !st_r.bvalid && st_r.wstrb0 &&
       st_r.awaddr == 12'h090) |=> pwm_cfg.duty[7:0] == $past(st_r.wdata))
      else $error("low duty byte not stored");
   timer_rsvd_a : assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && S_AXI_ARVALID_IN && st_r.arready && S_AXI_ARADDR_IN == 12'h094)
      |=> S_AXI_RVALID_OUT && !S_AXI_RDATA_OUT[3])
      else $error("timer reserved bit not zero");
   hi_rsvd_a : assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && S_AXI_ARVALID_IN && st_r.arready && S_AXI_ARADDR_IN == 12'h08C)
      |=> S_AXI_RDATA_OUT[7:2] == 6'h00)
      else $error("duty high reserved bits not zero");
   timer_off_a : assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && st_r.tmr_width == 4'h0) |=> !HSS_TIMER_OUT)
      else $error("timer on with off code");
   timer_on_a : assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
      (CE_IN && st_r.tmr_width == 4'hF) |=> HSS_TIMER_OUT)
      else $error("timer off with on code");
endmodule
`default_nettype wire

// *** test_hss_pwm2_duty_first_timer_configuration.sv ***
// self-checking bench for the pwm duty and timer register block
`timescale 1ns/1ps
`default_nettype none
`include "hpt_consts.svh"
module test_hss_pwm2_duty_first_timer_configuration;
   localparam int TICK  = 5;           // shortened timer tick keeps the run short
   localparam int LIMIT = 30000;       // cycle ceiling for the whole run
   localparam int STEP  = `HPT_PWM_SLOW_CYC;
   localparam int TP0   = 100 * TICK;  // period code 0 is 10 ms of 0.1 ms ticks
   logic        clk     = 1'b0;
   logic        rst     = 1'b1;
   logic [11:0] awaddr  = 12'h000;
   logic [11:0] araddr  = 12'h000;
   logic [31:0] wdata   = 32'h0;
   logic [3:0]  wstrb   = 4'h0;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic [7:0]  rnd     = 8'h3A;
   wire logic   awready, wready, bvalid, arready, rvalid, pwm, tmr;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];
   int          n_errors = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          hi;

   hpt_regs #(.TICK_CYC(TICK)) u_hpt_regs (
      .CLK_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1),
      .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
      .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
      .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
      .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
      .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
      .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
      .HSS_PWM_OUT(pwm), .HSS_TIMER_OUT(tmr));

   always #10 clk = ~clk;

   // ****************************************************************
   // reporting and comparison
   // ****************************************************************
   task automatic err(input string m);
      n_errors++;
      $display("ERROR %0t: %s", $time, m);
   endtask
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks_done++;
      if (got !== exp) err($sformatf("bus answer %h, expected %h", got, exp));
   endtask
   task automatic chk_rng(input int v, input int lo, input int up);
      checks_done++;
      if (v < lo || v > up) err($sformatf("on count %0d outside %0d..%0d", v, lo, up));
   endtask
   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // ****************************************************************
   // bus master: hold each channel until its own handshake edge
   // ****************************************************************
   task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                         input logic [1:0] r);
      logic aok, wok;
      bq.push_back(r);
      aok = 1'b0;
      wok = 1'b0;
      awaddr <= a;
      wdata <= {rnd, rnd, rnd, d};   // upper lanes carry noise the block must drop
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) aok = 1'b1;
         if (wvalid && wready) wok = 1'b1;
         if (aok) awvalid <= 1'b0;
         if (wok) wvalid <= 1'b0;
      end while (!(aok && wok));
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
      // one idle edge so a following call never reassigns bready in this step
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      rq.push_back({24'h0, d, r});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
      // one idle edge so a following call never reassigns rready in this step
      @(posedge clk);
   endtask
   task automatic meas(input int n, input bit sel, output int cnt);
      cnt = 0;
      repeat (n) begin
         @(posedge clk);
         cnt += (sel ? tmr : pwm) === 1'b1;
      end
   endtask

   // answer watcher: each answer takes the oldest note off its queue
   always @(posedge clk) begin
      if (rvalid && rready) begin
         if (rq.size() == 0) err("read answer with no note");
         else chk({rdata, rresp}, rq.pop_front());
      end
      if (bvalid && bready) begin
         if (bq.size() == 0) err("write answer with no note");
         else chk({32'h0, bresp}, {32'h0, bq.pop_front()});
      end
   end

   // hang guard: a run past the ceiling counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         err("run timed out");
         finish_test();
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      axi_rd(12'h090, 8'h00, `HPT_RESP_OKAY);
      axi_rd(12'h094, 8'h00, `HPT_RESP_OKAY);
      // counter starts at zero after reset, so on time ends eight steps after reset
      axi_wr(12'h090, 8'h08, 4'hF, `HPT_RESP_OKAY);
      meas(2600, 1'b0, hi);
      chk_rng(hi, 8 * STEP - 60, 8 * STEP);
      // duty bit 1 forced so no tiny duty; longest period so width never exceeds it
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         axi_wr(12'h090, rnd | 8'h02, 4'hF, `HPT_RESP_OKAY);
         axi_rd(12'h090, rnd | 8'h02, `HPT_RESP_OKAY);
         rnd = lfsr(rnd);
         axi_wr(12'h094, rnd | 8'h07, 4'hF, `HPT_RESP_OKAY);
         axi_rd(12'h094, (rnd | 8'h07) & 8'hF7, `HPT_RESP_OKAY);
      end
      axi_wr(12'h08C, 8'hFF, 4'hF, `HPT_RESP_OKAY);
      axi_rd(12'h08C, 8'h03, `HPT_RESP_OKAY);
      axi_wr(12'h088, 8'hFF, 4'hF, `HPT_RESP_OKAY);
      axi_rd(12'h088, 8'h80, `HPT_RESP_OKAY);
      // known low byte first, then a write with lane 0 off must leave it alone
      axi_wr(12'h090, 8'hC3, 4'hF, `HPT_RESP_OKAY);
      axi_wr(12'h090, 8'h5A, 4'hE, `HPT_RESP_OKAY);
      axi_rd(12'h090, 8'hC3, `HPT_RESP_OKAY);
      axi_wr(12'h0FC, 8'h11, 4'hF, `HPT_RESP_SLVERR);
      axi_rd(12'h0FC, 8'h00, `HPT_RESP_SLVERR);
      // all-zero duty must never switch on, all ones never off
      axi_wr(12'h08C, 8'h00, 4'hF, `HPT_RESP_OKAY);
      axi_wr(12'h090, 8'h00, 4'hF, `HPT_RESP_OKAY);
      repeat (3) @(posedge clk);
      meas(2000, 1'b0, hi);
      chk_rng(hi, 0, 0);
      axi_wr(12'h08C, 8'h03, 4'hF, `HPT_RESP_OKAY);
      axi_wr(12'h090, 8'hFF, 4'hF, `HPT_RESP_OKAY);
      repeat (3) @(posedge clk);
      meas(2000, 1'b0, hi);
      chk_rng(hi, 2000, 2000);
      // timer widths: off, one millisecond, on, over one full period
      axi_wr(12'h094, 8'h00, 4'hF, `HPT_RESP_OKAY);
      meas(TP0, 1'b1, hi);
      chk_rng(hi, 0, 0);
      axi_wr(12'h094, 8'h40, 4'hF, `HPT_RESP_OKAY);
      repeat (10) @(posedge clk);
      meas(TP0, 1'b1, hi);
      chk_rng(hi, 10 * TICK - 6, 10 * TICK + 6);
      axi_wr(12'h094, 8'hF0, 4'hF, `HPT_RESP_OKAY);
      repeat (3) @(posedge clk);
      meas(TP0, 1'b1, hi);
      chk_rng(hi, TP0, TP0);
      // both drives are now held on, so the status word shows both set
      axi_rd(12'h098, 8'h03, `HPT_RESP_OKAY);
      repeat (4) @(posedge clk);
      chk_rng(rq.size() + bq.size(), 0, 0);
      finish_test();
   end
endmodule
`default_nettype wire
